/* inc/mmd_defs.svh */
// Constants for the move, multiply and divide datapath.
// Included by the datapath module only; definitions only.
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// Register indices
`define MMD_LOW_REG_MAX 4'h7
`define MMD_SP_IDX 4'hD
`define MMD_PC_IDX 4'hF

// Cycle counts from acceptance to result, less one
`define MMD_MUL_SMALL_CNT 6'h1F
`define MMD_DIV_FAST_CNT 6'h10
`define MMD_DIV_SLOW_CNT 6'h21

// Divider iterations: two bits a cycle when fast, one when slow
`define MMD_DIV_FAST_ITERS 6'h10
`define MMD_DIV_SLOW_ITERS 6'h20

`endif

/* inc/mmd_pkg.sv */
// Types shared by the move, multiply and divide datapath and its users.
// Assumes the decode stage fills a request struct per instruction.
package mmd_pkg;

    // Operation selected by decode
    typedef enum logic [3:0] {
        OP_COPY_REGISTER,
        OP_COPY_REGISTER_SET_FLAGS,
        OP_LOAD_SHORT_IMMEDIATE,
        OP_LOAD_WIDE_IMMEDIATE,
        OP_INVERTED_COPY,
        OP_LOAD_TOP_HALFWORD,
        OP_MULTIPLY_LOW_WORD,
        OP_WORD_BYTE_SWAP,
        OP_HALFWORD_PAIR_SWAP,
        OP_SIGNED_HALFWORD_SWAP,
        OP_SIGNED_DIVIDE,
        OP_UNSIGNED_DIVIDE,
        OP_SIGN_EXTEND_BYTE,
        OP_SIGN_EXTEND_HALFWORD,
        OP_ZERO_EXTEND_BYTE,
        OP_ZERO_EXTEND_HALFWORD
    } mmd_op_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MUL,
        ST_DIV
    } mmd_state_e;

    // Condition flags
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } mmd_flags_s;

    // One instruction from decode
    typedef struct packed {
        mmd_op_e op;
        logic [3:0] dst;
        logic [3:0] src1;
        logic [3:0] src2;
        logic dst_omit;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] dst_val;
        logic [15:0] imm16;
    } mmd_req_s;

    // Write-back answer
    typedef struct packed {
        logic done;
        logic we;
        logic illegal;
        logic [3:0] dst;
        logic [31:0] value;
        logic flags_we;
        mmd_flags_s flags;
    } mmd_res_s;

endpackage : mmd_pkg

/* logic/mmd_alu.sv */
// Move, multiply, byte-reverse, extend and divide datapath of one core.
// Assumes decode supplies operand values and indices; one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
`include "mmd_defs.svh"

module mmd_alu #(
    parameter bit SMALL_MUL = 1'b0,
    parameter bit DIV_SLOW = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire mmd_pkg::mmd_req_s req,
    input wire mmd_pkg::mmd_flags_s flags_in,
    output logic busy,
    output var mmd_pkg::mmd_res_s res
);
    import mmd_pkg::*;

    // Index tests shared by the legality checks
    function automatic logic is_low(input logic [3:0] idx);
        is_low = (idx <= `MMD_LOW_REG_MAX);
    endfunction : is_low

    function automatic logic not_sp_pc(input logic [3:0] idx);
        not_sp_pc = (idx != `MMD_SP_IDX) && (idx != `MMD_PC_IDX);
    endfunction : not_sp_pc

    function automatic logic is_div(input mmd_op_e op);
        is_div = (op == OP_SIGNED_DIVIDE) || (op == OP_UNSIGNED_DIVIDE);
    endfunction : is_div

    // Register restrictions per operation; a refused encoding writes nothing
    function automatic logic op_legal(input mmd_req_s r, input logic [3:0] dst);
        op_legal = 1'b0;
        unique case (r.op)
            OP_COPY_REGISTER: op_legal = 1'b1;
            OP_COPY_REGISTER_SET_FLAGS,
            OP_INVERTED_COPY,
            OP_SIGN_EXTEND_BYTE,
            OP_SIGN_EXTEND_HALFWORD,
            OP_ZERO_EXTEND_BYTE,
            OP_ZERO_EXTEND_HALFWORD: op_legal = is_low(dst) && is_low(r.src2);
            OP_LOAD_SHORT_IMMEDIATE:
                op_legal = is_low(dst) && (r.imm16[15:8] == 8'h00);
            OP_LOAD_WIDE_IMMEDIATE: op_legal = is_low(dst);
            OP_LOAD_TOP_HALFWORD: op_legal = not_sp_pc(dst);
            OP_MULTIPLY_LOW_WORD:
                op_legal = is_low(dst) && is_low(r.src1) && (dst == r.src2);
            OP_WORD_BYTE_SWAP,
            OP_HALFWORD_PAIR_SWAP,
            OP_SIGNED_HALFWORD_SWAP: op_legal = is_low(dst) && is_low(r.src1);
            OP_SIGNED_DIVIDE,
            OP_UNSIGNED_DIVIDE:
                op_legal = not_sp_pc(dst) && not_sp_pc(r.src1) && not_sp_pc(r.src2);
        endcase
    endfunction : op_legal

    // Single-cycle results; divides take this path only when refused
    function automatic logic [31:0] quick_value(input mmd_req_s r, input logic [31:0] prod);
        quick_value = 32'h00000000;
        unique case (r.op)
            OP_COPY_REGISTER,
            OP_COPY_REGISTER_SET_FLAGS: quick_value = r.b;
            OP_LOAD_SHORT_IMMEDIATE: quick_value = {24'h000000, r.imm16[7:0]};
            OP_LOAD_WIDE_IMMEDIATE: quick_value = {16'h0000, r.imm16};
            OP_INVERTED_COPY: quick_value = ~r.b;
            OP_LOAD_TOP_HALFWORD: quick_value = {r.imm16, r.dst_val[15:0]};
            OP_MULTIPLY_LOW_WORD: quick_value = prod;
            OP_WORD_BYTE_SWAP:
                quick_value = {r.a[7:0], r.a[15:8], r.a[23:16], r.a[31:24]};
            OP_HALFWORD_PAIR_SWAP:
                quick_value = {r.a[23:16], r.a[31:24], r.a[7:0], r.a[15:8]};
            OP_SIGNED_HALFWORD_SWAP:
                quick_value = {{16{r.a[7]}}, r.a[7:0], r.a[15:8]};
            OP_SIGN_EXTEND_BYTE: quick_value = {{24{r.b[7]}}, r.b[7:0]};
            OP_SIGN_EXTEND_HALFWORD: quick_value = {{16{r.b[15]}}, r.b[15:0]};
            OP_ZERO_EXTEND_BYTE: quick_value = {24'h000000, r.b[7:0]};
            OP_ZERO_EXTEND_HALFWORD: quick_value = {16'h0000, r.b[15:0]};
            OP_SIGNED_DIVIDE,
            OP_UNSIGNED_DIVIDE: quick_value = 32'h00000000;
        endcase
    endfunction : quick_value

    // One restoring step on magnitudes: returns {remainder, quotient}
    function automatic logic [63:0] div_step(input logic [31:0] rem, input logic [31:0] quo,
                                             input logic [31:0] dvs);
        logic [32:0] trial;
        trial = {rem, quo[31]} - {1'b0, dvs};
        if (trial[32]) begin
            div_step = {rem[30:0], quo[31], quo[30:0], 1'b0};
        end else begin
            div_step = {trial[31:0], quo[30:0], 1'b1};
        end
    endfunction : div_step

    mmd_state_e state;
    mmd_req_s req_q;
    mmd_res_s next_res;
    logic [3:0] dst_q;
    logic [5:0] cnt;
    logic [5:0] iter;
    logic [31:0] mul_acc;
    logic [31:0] mul_a;
    logic [31:0] mul_b;
    logic [31:0] div_rem;
    logic [31:0] div_quo;
    logic [31:0] div_dvs;
    logic div_neg;
    logic div_dvz;

    logic accept;
    logic [3:0] dst_eff;
    logic legal;
    logic [31:0] prod_fast;
    logic [31:0] quick;
    logic sets_nz;
    logic goes_mul;
    logic start_mul;
    logic start_div;
    logic one_shot;
    logic signed_div;
    logic [31:0] a_mag;
    logic [31:0] b_mag;
    logic [5:0] div_cnt;
    logic [5:0] div_iters;
    logic [31:0] mul_next_acc;
    logic [63:0] step1;
    logic [63:0] step2;
    logic [63:0] step_sel;
    logic finish;
    logic [31:0] quo_final;
    logic [31:0] div_value;
    logic [31:0] out_value;
    logic out_flags_we;

    // Decode of the incoming request; busy requests are simply not taken
    assign accept = req_valid && (state == ST_IDLE);
    assign dst_eff = (is_div(req.op) && req.dst_omit) ? req.src1 : req.dst;
    assign legal = op_legal(req, dst_eff);
    // Low word is the same for signed and unsigned operands
    assign prod_fast = 32'(req.a * req.b);
    assign quick = quick_value(req, prod_fast);
    assign sets_nz = (req.op == OP_COPY_REGISTER_SET_FLAGS)
                  || (req.op == OP_LOAD_SHORT_IMMEDIATE)
                  || (req.op == OP_INVERTED_COPY)
                  || (req.op == OP_MULTIPLY_LOW_WORD);
    assign goes_mul = SMALL_MUL && (req.op == OP_MULTIPLY_LOW_WORD);
    assign start_mul = accept && legal && goes_mul;
    assign start_div = accept && legal && is_div(req.op);
    assign one_shot = accept && !start_mul && !start_div;

    // Divide runs on magnitudes; sign is restored at the end
    assign signed_div = (req.op == OP_SIGNED_DIVIDE);
    assign a_mag = (signed_div && req.a[31]) ? 32'(-req.a) : req.a;
    assign b_mag = (signed_div && req.b[31]) ? 32'(-req.b) : req.b;
    assign div_cnt = DIV_SLOW ? `MMD_DIV_SLOW_CNT : `MMD_DIV_FAST_CNT;
    assign div_iters = DIV_SLOW ? `MMD_DIV_SLOW_ITERS : `MMD_DIV_FAST_ITERS;

    // Iteration datapaths
    assign mul_next_acc = mul_acc + (mul_b[0] ? mul_a : 32'h00000000);
    assign step1 = div_step(div_rem, div_quo, div_dvs);
    assign step2 = div_step(step1[63:32], step1[31:0], div_dvs);
    assign step_sel = DIV_SLOW ? step1 : step2;

    // Finishing cycle; the fast divider folds its last step into it
    assign finish = (state != ST_IDLE) && (cnt == 6'h01);
    assign quo_final = (iter != 6'h00) ? step_sel[31:0] : div_quo;
    // Magnitude quotient negated, so results truncate towards zero
    assign div_value = div_dvz ? 32'h00000000
                     : (div_neg ? 32'(-quo_final) : quo_final);
    assign out_value = !finish ? quick : ((state == ST_MUL) ? mul_next_acc : div_value);
    // Top-halfword load, byte reversal, extends and divides never raise this
    assign out_flags_we = finish ? (state == ST_MUL)
                                 : (legal && sets_nz);

    // Sequencer for the multicycle operations
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            busy <= 1'b0;
        end else if (start_mul) begin
            state <= ST_MUL;
            cnt <= `MMD_MUL_SMALL_CNT;
            busy <= 1'b1;
        end else if (start_div) begin
            state <= ST_DIV;
            cnt <= div_cnt;
            busy <= 1'b1;
        end else if (finish) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            busy <= 1'b0;
        end else if (state != ST_IDLE) begin
            cnt <= cnt - 6'h01;
        end
    end

    // Shift-add multiplier; first step is taken at start to save a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            mul_acc <= 32'h00000000;
            mul_a <= 32'h00000000;
            mul_b <= 32'h00000000;
        end else if (start_mul) begin
            mul_acc <= req.b[0] ? req.a : 32'h00000000;
            mul_a <= {req.a[30:0], 1'b0};
            mul_b <= {1'b0, req.b[31:1]};
        end else if (state == ST_MUL) begin
            mul_acc <= mul_next_acc;
            mul_a <= {mul_a[30:0], 1'b0};
            mul_b <= {1'b0, mul_b[31:1]};
        end
    end

    // Restoring divider; a zero divisor just runs to an overridden result
    always_ff @(posedge clk) begin
        if (rst) begin
            div_rem <= 32'h00000000;
            div_quo <= 32'h00000000;
            div_dvs <= 32'h00000000;
            iter <= 6'h00;
            div_neg <= 1'b0;
            div_dvz <= 1'b0;
        end else if (start_div) begin
            div_rem <= 32'h00000000;
            div_quo <= a_mag;
            div_dvs <= b_mag;
            iter <= div_iters;
            div_neg <= signed_div && (req.a[31] ^ req.b[31]);
            div_dvz <= (req.b == 32'h00000000);
        end else if ((state == ST_DIV) && (iter != 6'h00)) begin
            div_rem <= step_sel[63:32];
            div_quo <= step_sel[31:0];
            iter <= iter - 6'h01;
        end
    end

    // Accepted request held for the write-back of multicycle results
    always_ff @(posedge clk) begin
        if (rst) begin
            req_q <= '0;
            dst_q <= 4'h0;
        end else if (accept) begin
            req_q <= req;
            dst_q <= dst_eff;
        end
    end

    // Write-back; unchanged flags are passed through from the core
    always_comb begin
        next_res = '0;
        if (one_shot || finish) begin
            next_res.done = 1'b1;
            next_res.we = finish || legal;
            next_res.illegal = one_shot && !legal;
            next_res.dst = finish ? dst_q : dst_eff;
            next_res.value = out_value;
        end
        next_res.flags_we = (one_shot || finish) && out_flags_we;
        next_res.flags.n = next_res.flags_we ? out_value[31] : flags_in.n;
        next_res.flags.z = next_res.flags_we ? (out_value == 32'h00000000) : flags_in.z;
        next_res.flags.c = flags_in.c;
        next_res.flags.v = flags_in.v;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            res <= '0;
        end else begin
            res <= next_res;
        end
    end

    // Checks on the write-back port
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_COPY: assert property (res.done && (req_q.op == OP_COPY_REGISTER)
        |-> res.we && (res.value == req_q.b) && !res.flags_we)
        else $error("register copy result or flags wrong");
    AST_COPY_NZ: assert property (res.done && res.we
        && (req_q.op == OP_COPY_REGISTER_SET_FLAGS)
        |-> res.flags_we && (res.flags.z == (res.value == 32'h00000000))
            && (res.flags.n == res.value[31]))
        else $error("flag-setting copy flags wrong");
    AST_INVERT: assert property (res.done && res.we
        && (req_q.op == OP_INVERTED_COPY) |-> res.value == ~req_q.b)
        else $error("inverted copy result wrong");
    AST_KEEP_CV: assert property (res.done && res.flags_we
        |-> (res.flags.c == $past(flags_in.c)) && (res.flags.v == $past(flags_in.v)))
        else $error("carry or overflow disturbed");
    AST_SHORT_IMM: assert property (res.done && res.we
        && (req_q.op == OP_LOAD_SHORT_IMMEDIATE)
        |-> res.value == {24'h000000, req_q.imm16[7:0]})
        else $error("short immediate result wrong");
    AST_TOP_HALF: assert property (res.done && res.we
        && (req_q.op == OP_LOAD_TOP_HALFWORD)
        |-> res.value == {req_q.imm16, req_q.dst_val[15:0]})
        else $error("top halfword result wrong");
    AST_TOP_FLAGS: assert property (res.done
        && (req_q.op == OP_LOAD_TOP_HALFWORD) |-> !res.flags_we)
        else $error("top halfword load touched flags");
    AST_TOP_DST: assert property ($past(accept) && ($past(req.op) == OP_LOAD_TOP_HALFWORD)
        && (($past(req.dst) == `MMD_SP_IDX) || ($past(req.dst) == `MMD_PC_IDX))
        |-> res.illegal && !res.we)
        else $error("top halfword load to stack pointer or program counter taken");
    AST_MUL: assert property (res.done && res.we
        && (req_q.op == OP_MULTIPLY_LOW_WORD) |-> res.value == 32'(req_q.a * req_q.b))
        else $error("multiply low word wrong");
    AST_MUL_TIME: assert property (start_mul |-> ##31 !res.done ##1 res.done)
        else $error("iterative multiply not 32 cycles");
    AST_DIV_FAST: assert property (start_div && !DIV_SLOW |-> ##17 res.done)
        else $error("fast divide not 17 cycles");
    AST_DIV_SLOW: assert property (start_div && DIV_SLOW |-> ##34 res.done)
        else $error("slow divide not 34 cycles");
    AST_UNSIGNED_DIVIDE: assert property (res.done && res.we && (req_q.op == OP_UNSIGNED_DIVIDE)
        && (req_q.b != 32'h00000000) |-> res.value == req_q.a / req_q.b)
        else $error("unsigned quotient wrong");
    AST_DIV_ZERO: assert property (res.done && !res.illegal && is_div(req_q.op)
        && (req_q.b == 32'h00000000) |-> res.we && (res.value == 32'h00000000))
        else $error("divide by zero not zero");

    COV_MUL: cover property (start_mul ##32 res.done);
    COV_DIV: cover property (start_div && (req.b == 32'h00000000));
    COV_REFUSED: cover property (one_shot && !legal);
endmodule : mmd_alu

`default_nettype wire

/* sim/test_mmd_alu.sv */
// Self-checking bench for the move, multiply and divide datapath.
// Assumes mmd_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ns
`default_nettype none

module test_mmd_alu;
    import mmd_pkg::*;

    typedef struct {
        mmd_res_s r;
        int acc;
        int lat;
    } mmd_note_s;

    logic clk = 1'b0;
    logic rst;
    logic req_valid;
    mmd_req_s req;
    mmd_flags_s flags_in;
    logic busy;
    mmd_res_s res;
    mmd_note_s notes[$];
    int cyc = 0;
    int failures = 0;
    int checked = 0;

    // Small multiplier and fast divider: answers after 32 and 17 edges
    mmd_alu #(.SMALL_MUL(1'b1), .DIV_SLOW(1'b0)) dut (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .flags_in(flags_in),
        .busy(busy), .res(res)
    );

    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Edge counter for latency measurement
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    function automatic logic lo(input logic [3:0] r);
        return r <= 4'h7;
    endfunction : lo

    // Neither stack pointer nor program counter
    function automatic logic nsp(input logic [3:0] r);
        return r != 4'hD && r != 4'hF;
    endfunction : nsp

    // Expected answer worked out from the instruction semantics
    function automatic mmd_res_s model(input mmd_req_s q, input mmd_flags_s f);
        mmd_res_s r;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] v;
        logic ok;
        logic fw;
        a = q.a;
        b = q.b;
        r = '0;
        // Divide without destination writes back to the dividend register
        r.dst = (q.dst_omit && q.op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE}) ?
            q.src1 : q.dst;
        case (q.op)
            OP_COPY_REGISTER: ok = 1'b1;
            OP_COPY_REGISTER_SET_FLAGS, OP_INVERTED_COPY, OP_SIGN_EXTEND_BYTE,
            OP_SIGN_EXTEND_HALFWORD, OP_ZERO_EXTEND_BYTE,
            OP_ZERO_EXTEND_HALFWORD: ok = lo(q.dst) && lo(q.src2);
            OP_LOAD_SHORT_IMMEDIATE: ok = lo(q.dst) && q.imm16[15:8] == 8'h00;
            OP_LOAD_WIDE_IMMEDIATE: ok = lo(q.dst);
            OP_LOAD_TOP_HALFWORD: ok = nsp(q.dst);
            OP_MULTIPLY_LOW_WORD: ok = lo(q.dst) && lo(q.src1) && q.dst == q.src2;
            OP_WORD_BYTE_SWAP, OP_HALFWORD_PAIR_SWAP,
            OP_SIGNED_HALFWORD_SWAP: ok = lo(q.dst) && lo(q.src1);
            default: ok = nsp(r.dst) && nsp(q.src1) && nsp(q.src2);
        endcase
        case (q.op)
            OP_COPY_REGISTER, OP_COPY_REGISTER_SET_FLAGS: v = b;
            OP_LOAD_SHORT_IMMEDIATE: v = {24'h000000, q.imm16[7:0]};
            OP_LOAD_WIDE_IMMEDIATE: v = {16'h0000, q.imm16};
            OP_INVERTED_COPY: v = ~b;
            OP_LOAD_TOP_HALFWORD: v = {q.imm16, q.dst_val[15:0]};
            OP_MULTIPLY_LOW_WORD: v = a * b;
            OP_WORD_BYTE_SWAP: v = {a[7:0], a[15:8], a[23:16], a[31:24]};
            OP_HALFWORD_PAIR_SWAP: v = {a[23:16], a[31:24], a[7:0], a[15:8]};
            OP_SIGNED_HALFWORD_SWAP: v = {{16{a[7]}}, a[7:0], a[15:8]};
            // Kept out of a conditional, whose unsigned arm would make the divide unsigned
            OP_SIGNED_DIVIDE: begin
                if (b == 32'h0) begin
                    v = 32'h0;
                end else if (a == 32'h8000_0000 && b == 32'hFFFF_FFFF) begin
                    v = a;
                end else begin
                    v = $signed(a) / $signed(b);
                end
            end
            OP_UNSIGNED_DIVIDE: v = (b == 32'h0) ? 32'h0 : a / b;
            OP_SIGN_EXTEND_BYTE: v = {{24{b[7]}}, b[7:0]};
            OP_SIGN_EXTEND_HALFWORD: v = {{16{b[15]}}, b[15:0]};
            OP_ZERO_EXTEND_BYTE: v = {24'h000000, b[7:0]};
            default: v = {16'h0000, b[15:0]};
        endcase
        fw = q.op inside {OP_COPY_REGISTER_SET_FLAGS, OP_LOAD_SHORT_IMMEDIATE,
            OP_INVERTED_COPY, OP_MULTIPLY_LOW_WORD};
        r.done = 1'b1;
        r.we = ok;
        r.illegal = !ok;
        r.value = v;
        r.flags_we = ok && fw;
        r.flags = r.flags_we ? {v[31], v == 32'h0, f.c, f.v} : f;
        return r;
    endfunction : model

    // Issue one request; multicycle ones are followed by refused traffic while busy
    task automatic send(input mmd_req_s q, input mmd_flags_s f);
        mmd_note_s n;
        int k;
        n.r = model(q, f);
        // Counted from the edge count before the taking edge, so latency is N
        n.acc = cyc;
        n.lat = n.r.illegal ? 1 : (q.op == OP_MULTIPLY_LOW_WORD) ? 32 :
            (q.op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE}) ? 17 : 1;
        req_valid = 1'b1;
        req = q;
        flags_in = f;
        notes.push_back(n);
        @(negedge clk);
        if (n.lat > 1) begin
            check("busy", busy, 64'h1);
            req.op = OP_COPY_REGISTER;
            for (k = 0; k < 60 && notes.size() != 0; k++) begin
                req_valid = (k < 3);
                @(negedge clk);
            end
        end
    endtask : send

    task automatic dir(input mmd_op_e op, input logic [3:0] d, input logic [3:0] s1,
        input logic [3:0] s2, input logic [31:0] a, input logic [31:0] b,
        input logic [15:0] imm, input logic om);
        mmd_req_s q;
        q = '{op: op, dst: d, src1: s1, src2: s2, dst_omit: om, a: a, b: b,
            dst_val: 32'h1357_9BDF, imm16: imm};
        send(q, mmd_flags_s'(4'($urandom)));
    endtask : dir

    // Random request, biased towards legal registers and awkward divisors
    task automatic rnd;
        mmd_req_s q;
        q.op = mmd_op_e'(4'($urandom));
        q.dst = 4'($urandom_range(8, 0));
        q.src1 = ($urandom_range(7, 0) == 0) ? 4'hD : 4'($urandom_range(8, 0));
        q.src2 = ($urandom_range(1, 0) == 0) ? q.dst : 4'($urandom_range(15, 0));
        q.dst_omit = 1'($urandom);
        q.a = $urandom;
        q.b = ($urandom_range(3, 0) == 0) ? 32'h0 : $urandom;
        q.dst_val = $urandom;
        q.imm16 = 16'($urandom);
        if ($urandom_range(1, 0) == 0) q.imm16[15:8] = 8'h00;
        send(q, mmd_flags_s'(4'($urandom)));
    endtask : rnd

    task automatic drain;
        int k;
        req_valid = 1'b0;
        @(negedge clk);
        for (k = 0; k < 60 && notes.size() != 0; k++) @(negedge clk);
        check("pending", notes.size(), 64'h0);
    endtask : drain

    // Output watcher: each done retires the oldest expectation
    always @(negedge clk) begin
        mmd_note_s n;
        if (!rst && res.done === 1'b1) begin
            if (notes.size() == 0) begin
                check("spurious_done", 64'h1, 64'h0);
            end else begin
                n = notes.pop_front();
                check("latency", cyc - n.acc, n.lat);
                check("illegal", res.illegal, n.r.illegal);
                check("we", res.we, n.r.we);
                if (n.r.we === 1'b1) begin
                    check("dst", res.dst, n.r.dst);
                    check("value", res.value, n.r.value);
                end
                check("flags_we", res.flags_we, n.r.flags_we);
                check("flags", res.flags, n.r.flags);
            end
        end
    end

    // Main sequence
    initial begin
        int k;
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        flags_in = '0;
        void'($urandom(58));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("reset_state", {busy, res.done}, 64'h0);
        for (k = 0; k < 16; k++) begin
            dir(mmd_op_e'(k), 4'h1, 4'h2, 4'h1, 32'h8123_45F6, 32'hFFFF_FF85, 16'h00A5, 1'b0);
        end
        dir(OP_COPY_REGISTER, 4'hA, 4'h0, 4'hF, 32'h0, 32'h0000_0102, 16'h0, 1'b0);
        dir(OP_COPY_REGISTER_SET_FLAGS, 4'h2, 4'h0, 4'h3, 32'h0, 32'h0, 16'h0, 1'b0);
        dir(OP_COPY_REGISTER_SET_FLAGS, 4'h2, 4'h0, 4'h9, 32'h0, 32'h5, 16'h0, 1'b0);
        dir(OP_INVERTED_COPY, 4'h7, 4'h0, 4'h6, 32'h0, 32'hFFFF_FFFF, 16'h0, 1'b0);
        dir(OP_LOAD_SHORT_IMMEDIATE, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 16'h00FF, 1'b0);
        dir(OP_LOAD_SHORT_IMMEDIATE, 4'h0, 4'h0, 4'h0, 32'h0, 32'h0, 16'h0100, 1'b0);
        dir(OP_LOAD_WIDE_IMMEDIATE, 4'h7, 4'h0, 4'h0, 32'h0, 32'h0, 16'hFFFF, 1'b0);
        dir(OP_LOAD_WIDE_IMMEDIATE, 4'h8, 4'h0, 4'h0, 32'h0, 32'h0, 16'h0000, 1'b0);
        dir(OP_LOAD_TOP_HALFWORD, 4'hC, 4'h0, 4'h0, 32'h0, 32'h0, 16'hF123, 1'b0);
        dir(OP_LOAD_TOP_HALFWORD, 4'hD, 4'h0, 4'h0, 32'h0, 32'h0, 16'h0000, 1'b0);
        dir(OP_LOAD_TOP_HALFWORD, 4'hF, 4'h0, 4'h0, 32'h0, 32'h0, 16'h8000, 1'b0);
        dir(OP_MULTIPLY_LOW_WORD, 4'h3, 4'h4, 4'h3, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0, 1'b0);
        dir(OP_MULTIPLY_LOW_WORD, 4'h3, 4'h4, 4'h3, 32'h0001_0000, 32'h0001_0000, 16'h0, 1'b0);
        dir(OP_MULTIPLY_LOW_WORD, 4'h3, 4'h4, 4'h5, 32'h2, 32'h3, 16'h0, 1'b0);
        dir(OP_WORD_BYTE_SWAP, 4'h8, 4'h1, 4'h0, 32'h1122_3344, 32'h0, 16'h0, 1'b0);
        dir(OP_SIGNED_DIVIDE, 4'h1, 4'h2, 4'h3, 32'hFFFF_FFF9, 32'h2, 16'h0, 1'b0);
        dir(OP_SIGNED_DIVIDE, 4'h1, 4'h2, 4'h3, 32'h7, 32'hFFFF_FFFE, 16'h0, 1'b0);
        dir(OP_SIGNED_DIVIDE, 4'h1, 4'h2, 4'h3, 32'h8000_0000, 32'hFFFF_FFFF, 16'h0, 1'b0);
        dir(OP_UNSIGNED_DIVIDE, 4'h1, 4'h2, 4'h3, 32'hFFFF_FFFF, 32'h3, 16'h0, 1'b0);
        dir(OP_UNSIGNED_DIVIDE, 4'h1, 4'h2, 4'h3, 32'h5, 32'h0, 16'h0, 1'b0);
        dir(OP_UNSIGNED_DIVIDE, 4'h9, 4'hB, 4'h3, 32'h64, 32'h7, 16'h0, 1'b1);
        dir(OP_SIGNED_DIVIDE, 4'hD, 4'h2, 4'h3, 32'h64, 32'h7, 16'h0, 1'b0);
        drain();
        for (k = 0; k < 300; k++) rnd();
        drain();
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(40000 * 100);
        failures++;
        results();
    end

endmodule : test_mmd_alu

`default_nettype wire
